// File: design/tw_config_port.sv
// Three-wire write-only configuration port with its register file and
// control decode. Assumes pins are asynchronous to clk; cal results are on clk.
//
// Contract
// - Sample load and data each serial rising edge
// - Frame starts at first low edge; code needs one high edge first after reset or mode going high
// - First three low edges carry address MSB-first
// - Next sixteen low edges carry data MSB-first
// - Twentieth low edge writes the addressed register
// - Early high edge aborts, nothing written
// - Extra low edges after write ignored
// - One high edge separates two frames
// - Full 16 bits sent, unused bits dropped; code stores all 16 bits in the register file
// - Eight write-only registers of sixteen bits
// - Mode pin resets registers any time
// - Standby, binary, demux and decimation fields
// - Input and clock routing fields
// - Calibration control: start, keep, or none
// - Keep uses last calibration or defaults
// - Manual mode uses offset and gain registers
// - Bit nine zero; bit fourteen sets ready rate, only while the demux bit is set
// - One shared overrange bit in demux mode
// - Mode low disables port, settings default
// - Busy output high during calibration
`timescale 1ns/1ps
module tw_config_port
    import tw_pkg::*;
#(
    parameter int CAL_CYC_AB11 = TW_TCAL_AB11,
    parameter int CAL_CYC_AB10 = TW_TCAL_AB10,
    parameter int CAL_CYC_AB01 = TW_TCAL_AB01,
    parameter int CAL_CYC_AB00 = TW_TCAL_AB00
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sldn,
    input wire logic sdata,
    input wire logic mode,
    input wire logic [1:0] overrange_in,
    input wire logic [15:0] cal_offset_result,
    input wire logic [15:0] cal_gain_result,
    output logic [1:0] standby,
    output logic binary_out,
    output logic output_demux,
    output logic [1:0] input_route,
    output logic [1:0] clock_route,
    output logic decimation,
    output logic ready_rate,
    output logic cal_busy,
    output logic [15:0] applied_offset,
    output logic [15:0] applied_gain,
    output logic [1:0] overrange_out,
    output logic [127:0] cfg_flat
);
    localparam logic [15:0] RST_VALS [0:7] = '{TW_RST_MAIN, TW_RST_GAIN, TW_RST_OFFSET_COMP,
        TW_RST_GAIN_COMP, TW_RST_SETTLE, TW_RST_TEST, TW_RST_SELFTEST, TW_RST_DELAY};

    tw_wr_if wr ();
    logic [1:0] mode_q;
    logic [15:0] cfg [0:TW_NREGS-1];
    logic [15:0] main_w;
    logic [1:0] cal_sel;
    logic wr_ok;
    logic cal_go;
    tw_cal_state_t cal_state;
    tw_cal_state_t next_cal_state;
    logic [TW_CAL_CNT_W-1:0] cal_cnt;
    logic [15:0] stored_offset;
    logic [15:0] stored_gain;

    function automatic logic [TW_CAL_CNT_W-1:0] cal_len(input logic [1:0] ab);
        unique case (ab)
            2'b11: cal_len = TW_CAL_CNT_W'(CAL_CYC_AB11);
            2'b10: cal_len = TW_CAL_CNT_W'(CAL_CYC_AB10);
            2'b01: cal_len = TW_CAL_CNT_W'(CAL_CYC_AB01);
            2'b00: cal_len = TW_CAL_CNT_W'(CAL_CYC_AB00);
        endcase
    endfunction

    // Mode pin is asynchronous; two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= 2'h0;
        end else begin
            mode_q <= {mode_q[0], mode};
        end
    end

    assign wr.port_en = mode_q[1];

    tw_frame_rx u_rx (
        .clk(clk),
        .rst(rst),
        .sclk(sclk),
        .sldn(sldn),
        .sdata(sdata),
        .wr(wr)
    );

    // Writes are inhibited while calibrating
    assign wr_ok = wr.wr_valid && cal_state == TW_CAL_IDLE;
    assign cal_go = wr_ok && wr.wr_addr == TW_REG_MAIN
        && wr.wr_data[TW_F_CAL_LO+:2] == TW_CAL_START;

    // Register file, write-only from the link
    always_ff @(posedge clk) begin
        if (rst || !mode_q[1]) begin
            for (int i = 0; i < TW_NREGS; i++) begin
                cfg[i] <= RST_VALS[i];
            end
        end else if (wr_ok) begin
            cfg[wr.wr_addr] <= wr.wr_data;
        end
    end

    assign main_w = cfg[TW_REG_MAIN];
    assign cal_sel = main_w[TW_F_CAL_LO+:2];

    always_comb begin
        next_cal_state = cal_state;
        unique case (cal_state)
            TW_CAL_IDLE: begin
                if (cal_go) begin
                    next_cal_state = TW_CAL_RUN;
                end
            end
            TW_CAL_RUN: begin
                if (cal_cnt == '0) begin
                    next_cal_state = TW_CAL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || !mode_q[1]) begin
            cal_state <= TW_CAL_IDLE;
        end else begin
            cal_state <= next_cal_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !mode_q[1]) begin
            cal_cnt <= '0;
        end else if (cal_go) begin
            cal_cnt <= cal_len(wr.wr_data[TW_F_WAIT_LO+:2]) - TW_CAL_CNT_W'(1);
        end else if (cal_state == TW_CAL_RUN && cal_cnt != '0) begin
            cal_cnt <= cal_cnt - TW_CAL_CNT_W'(1);
        end
    end

    // Corrections found by the last calibration, defaults until one completes
    always_ff @(posedge clk) begin
        if (rst || !mode_q[1]) begin
            stored_offset <= TW_RST_OFFSET_COMP;
            stored_gain <= TW_RST_GAIN_COMP;
        end else if (cal_state == TW_CAL_RUN && cal_cnt == '0) begin
            stored_offset <= cal_offset_result;
            stored_gain <= cal_gain_result;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cal_busy <= 1'b0;
        end else begin
            cal_busy <= next_cal_state == TW_CAL_RUN;
        end
    end

    // Control outputs are registered so an update never glitches them
    always_ff @(posedge clk) begin
        if (rst) begin
            standby <= TW_RST_MAIN[TW_F_STBY_LO+:2];
            binary_out <= TW_RST_MAIN[TW_F_BINARY];
            output_demux <= TW_RST_MAIN[TW_F_DEMUX];
            input_route <= TW_RST_MAIN[TW_F_INSEL_LO+:2];
            clock_route <= TW_RST_MAIN[TW_F_CLKSEL_LO+:2];
            decimation <= TW_RST_MAIN[TW_F_DECIM];
            ready_rate <= 1'b0;
        end else if (next_cal_state == TW_CAL_RUN) begin
            standby <= main_w[TW_F_STBY_LO+:2];
            binary_out <= 1'b1;
            output_demux <= 1'b0;
            input_route <= main_w[TW_F_INSEL_LO+:2];
            clock_route <= main_w[TW_F_CLKSEL_LO+:2];
            decimation <= 1'b1;
            ready_rate <= 1'b0;
        end else begin
            standby <= main_w[TW_F_STBY_LO+:2];
            binary_out <= main_w[TW_F_BINARY];
            output_demux <= main_w[TW_F_DEMUX];
            input_route <= main_w[TW_F_INSEL_LO+:2];
            clock_route <= main_w[TW_F_CLKSEL_LO+:2];
            decimation <= main_w[TW_F_DECIM];
            ready_rate <= main_w[TW_F_DEMUX] & main_w[TW_F_RATE];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            applied_offset <= TW_RST_OFFSET_COMP;
            applied_gain <= TW_RST_GAIN_COMP;
        end else if (cal_sel == TW_CAL_MANUAL) begin
            applied_offset <= cfg[TW_REG_OFFSET_COMP];
            applied_gain <= cfg[TW_REG_GAIN_COMP];
        end else begin
            applied_offset <= stored_offset;
            applied_gain <= stored_gain;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            overrange_out <= 2'h0;
        end else if (output_demux) begin
            overrange_out <= {2{|overrange_in}};
        end else begin
            overrange_out <= overrange_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_flat <= '0;
        end else begin
            for (int i = 0; i < TW_NREGS; i++) begin
                cfg_flat[i*16+:16] <= cfg[i];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cal_request;
        cal_go;
    endsequence

    sequence s_busy_run;
        cal_busy[*8];
    endsequence

    sequence s_cal_finish;
        cal_state == TW_CAL_RUN && cal_cnt == '0 && mode_q[1];
    endsequence

    a_mode_resets: assert property (!mode_q[1] |=> cfg[TW_REG_MAIN] == TW_RST_MAIN)
        else $error("mode low did not restore defaults");
    a_busy_start: assert property (s_cal_request |=> s_busy_run)
        else $error("busy not raised for calibration");
    a_busy_ends: assert property ($fell(cal_busy) && mode_q[1] |-> $past(cal_cnt) == '0)
        else $error("busy dropped early");
    a_manual_comp: assert property (cal_sel == TW_CAL_MANUAL ##1 cal_sel == TW_CAL_MANUAL
        |-> applied_offset == $past(cfg[TW_REG_OFFSET_COMP]))
        else $error("manual offset not applied");
    a_keep_stored: assert property (cal_sel == TW_CAL_KEEP |=> applied_gain == $past(stored_gain))
        else $error("stored gain not applied");
    a_shared_ovr: assert property ($past(output_demux) |-> overrange_out[0] == overrange_out[1])
        else $error("demux overrange not shared");
    a_cal_forces: assert property (cal_busy |-> decimation && !output_demux && binary_out)
        else $error("calibration setup not forced");
    a_write_lands: assert property (wr_ok && mode_q[1] ##1 mode_q[1]
        |-> cfg[$past(wr.wr_addr)] == $past(wr.wr_data))
        else $error("register not written");
    a_demux_follows: assert property (mode_q[1] && !cal_busy
        |-> output_demux == $past(main_w[TW_F_DEMUX]))
        else $error("demux output not following register");

    // Control outputs follow the register one clock later outside calibration
    a_binary_follows: assert property (!cal_busy |-> binary_out == $past(main_w[TW_F_BINARY]))
        else $error("binary output not following register");
    a_misc_follows: assert property (!cal_busy
        |-> decimation == $past(main_w[TW_F_DECIM]) && standby == $past(main_w[TW_F_STBY_LO+:2]))
        else $error("standby or decimation not following register");
    a_route_follows: assert property (input_route == $past(main_w[TW_F_INSEL_LO+:2])
        && clock_route == $past(main_w[TW_F_CLKSEL_LO+:2]))
        else $error("routing outputs not following register");
    a_ready_gated: assert property (!cal_busy
        |-> ready_rate == ($past(main_w[TW_F_DEMUX]) && $past(main_w[TW_F_RATE])))
        else $error("ready rate not gated by demux");

    // Calibration bookkeeping, manual gain and overrange pass-through
    a_cal_capture: assert property (s_cal_finish |=> stored_gain == $past(cal_gain_result)
        && stored_offset == $past(cal_offset_result))
        else $error("calibration results not stored");
    a_cal_locks: assert property (cal_state == TW_CAL_RUN && mode_q[1]
        |=> cfg[TW_REG_MAIN] == $past(cfg[TW_REG_MAIN]))
        else $error("register written during calibration");
    a_manual_gain: assert property (cal_sel == TW_CAL_MANUAL
        |=> applied_gain == $past(cfg[TW_REG_GAIN_COMP]))
        else $error("manual gain not applied");
    a_mode_idle: assert property (!mode_q[1] |-> ##2 !cal_busy)
        else $error("busy held while port disabled");
    a_ovr_single: assert property (!$past(output_demux) && !$past(rst)
        |-> overrange_out == $past(overrange_in))
        else $error("overrange not passed per channel");
endmodule

// File: design/tw_pkg.sv
// Shared constants of the three-wire configuration port.
// Assumes one 10 MHz system clock; pin timing is handled by the sampling logic.
package tw_pkg;
    localparam int TW_ADDR_W = 3;
    localparam int TW_DATA_W = 16;
    localparam int TW_NREGS = 8;
    localparam int TW_FRAME_BITS = 19;
    localparam logic [4:0] TW_CNT_ADDR_END = 5'h03;
    localparam logic [4:0] TW_CNT_COMMIT = 5'h13;
    localparam logic [4:0] TW_CNT_DONE = 5'h14;

    // Register indices
    localparam logic [2:0] TW_REG_MAIN = 3'h0;
    localparam logic [2:0] TW_REG_GAIN = 3'h1;
    localparam logic [2:0] TW_REG_OFFSET_COMP = 3'h2;
    localparam logic [2:0] TW_REG_GAIN_COMP = 3'h3;
    localparam logic [2:0] TW_REG_SETTLE = 3'h4;
    localparam logic [2:0] TW_REG_TEST = 3'h5;
    localparam logic [2:0] TW_REG_SELFTEST = 3'h6;
    localparam logic [2:0] TW_REG_DELAY = 3'h7;

    // Reset values
    localparam logic [15:0] TW_RST_MAIN = 16'h00B4;
    localparam logic [15:0] TW_RST_GAIN = 16'h8080;
    localparam logic [15:0] TW_RST_OFFSET_COMP = 16'h8080;
    localparam logic [15:0] TW_RST_GAIN_COMP = 16'h0080;
    localparam logic [15:0] TW_RST_SETTLE = 16'h8424;
    localparam logic [15:0] TW_RST_TEST = 16'h0000;
    localparam logic [15:0] TW_RST_SELFTEST = 16'h0000;
    localparam logic [15:0] TW_RST_DELAY = 16'h0424;

    // Field positions of main_control
    localparam int TW_F_STBY_LO = 0;
    localparam int TW_F_BINARY = 2;
    localparam int TW_F_DEMUX = 3;
    localparam int TW_F_INSEL_LO = 4;
    localparam int TW_F_CLKSEL_LO = 6;
    localparam int TW_F_DECIM = 8;
    localparam int TW_F_RSVD = 9;
    localparam int TW_F_CAL_LO = 10;
    localparam int TW_F_WAIT_LO = 12;
    localparam int TW_F_RATE = 14;

    localparam logic [1:0] TW_CAL_START = 2'b11;
    localparam logic [1:0] TW_CAL_KEEP = 2'b01;
    localparam logic [1:0] TW_CAL_MANUAL = 2'b00;

    // Calibration length in master clock periods per wait setting
    localparam int TW_TCAL_AB11 = 10112;
    localparam int TW_TCAL_AB10 = 6016;
    localparam int TW_TCAL_AB01 = 3968;
    localparam int TW_TCAL_AB00 = 2944;
    localparam int TW_CAL_CNT_W = 14;

    typedef enum logic [0:0] {
        TW_CAL_IDLE = 1'b0,
        TW_CAL_RUN = 1'b1
    } tw_cal_state_t;
endpackage

// File: design/tw_wr_if.sv
// Carries completed register writes from the frame receiver to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface tw_wr_if;
    logic port_en;
    logic wr_valid;
    logic [2:0] wr_addr;
    logic [15:0] wr_data;

    modport rx (input port_en, output wr_valid, output wr_addr, output wr_data);
    modport core (output port_en, input wr_valid, input wr_addr, input wr_data);
endinterface

// File: design/tw_frame_rx.sv
// Serial frame receiver: samples the three pins on clk and decodes 19-bit frames.
// Assumes the serial clock is much slower than clk, so every level is seen.
`timescale 1ns/1ps
module tw_frame_rx
    import tw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sldn,
    input wire logic sdata,
    tw_wr_if.rx wr
);
    logic [2:0] sclk_q;
    logic [1:0] sldn_q;
    logic [1:0] sdata_q;
    logic armed;
    logic [4:0] cnt;
    logic [18:0] shreg;
    logic edge_rise;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_q <= 3'h0;
            sldn_q <= 2'h3;
            sdata_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk};
            sldn_q <= {sldn_q[0], sldn};
            sdata_q <= {sdata_q[0], sdata};
        end
    end

    // Each rising serial clock edge is one cycle
    assign edge_rise = sclk_q[1] & ~sclk_q[2];

    always_ff @(posedge clk) begin
        if (rst || !wr.port_en) begin
            armed <= 1'b0;
            cnt <= 5'h00;
            shreg <= '0;
        end else if (edge_rise) begin
            if (sldn_q[1]) begin
                armed <= 1'b1;
                cnt <= 5'h00;
            end else if (armed && cnt < TW_CNT_COMMIT) begin
                shreg <= {shreg[17:0], sdata_q[1]};
                cnt <= cnt + 5'h01;
            end else if (armed && cnt == TW_CNT_COMMIT) begin
                cnt <= TW_CNT_DONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !wr.port_en) begin
            wr.wr_valid <= 1'b0;
            wr.wr_addr <= 3'h0;
            wr.wr_data <= 16'h0000;
        end else begin
            wr.wr_valid <= edge_rise && !sldn_q[1] && armed && cnt == TW_CNT_COMMIT;
            if (edge_rise && !sldn_q[1] && armed && cnt == TW_CNT_COMMIT) begin
                wr.wr_addr <= shreg[18:16];
                wr.wr_data <= shreg[15:0];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !wr.port_en);

    a_commit_low_edge: assert property (wr.wr_valid |-> $past(edge_rise) && !$past(sldn_q[1]))
        else $error("write without a low serial edge");
    a_abort_no_write: assert property (edge_rise && sldn_q[1] |=> !wr.wr_valid)
        else $error("write on a high load cycle");
    a_single_commit: assert property (wr.wr_valid |=> (!wr.wr_valid)[*4])
        else $error("second write in one frame");
endmodule

// File: bench/tw_host_model.sv
// Host controller model: drives serial clock, load and data of the port.
// Assumes it shares clk with the design; the serial clock idles low between frames.
`timescale 1ns/1ps
module tw_host_model (
    input wire logic clk,
    output logic sclk,
    output logic sldn,
    output logic sdata
);
    initial begin
        sclk = 1'b0;
        sldn = 1'b1;
        sdata = 1'b0;
    end

    // One serial cycle: 3 clk low, 5 clk high, 800 ns
    task automatic serial_cycle(input logic ld, input logic dv);
        @(posedge clk);
        sclk <= 1'b0;
        sldn <= ld;
        sdata <= dv;
        repeat (3) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // Frame of nlow low cycles; arm adds a leading high cycle
    task automatic frame(input logic [2:0] addr, input logic [15:0] data, input int nlow, input bit arm);
        logic bitv;
        if (arm) serial_cycle(1'b1, ~sdata);
        for (int i = 0; i < nlow; i++) begin
            if (i < 3) bitv = addr[2 - i];
            else if (i < 19) bitv = data[18 - i];
            else bitv = ~sdata;
            serial_cycle(1'b0, bitv);
        end
        serial_cycle(1'b1, ~sdata);
        @(posedge clk);
        sclk <= 1'b0;
        sdata <= ~sdata;
    endtask
endmodule

// File: bench/three_wire_config_port_tb_top.sv
// Self-checking bench of the configuration port, frames sent by the host model.
// Assumes calibration lengths are shortened to 24, 20, 18 and 16 clk through the parameters.
`timescale 1ns/1ps
module three_wire_config_port_tb_top
    import tw_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode = 1'b1;
    logic [1:0] overrange_in = 2'b00;
    logic [15:0] cal_offset_result = 16'h0000;
    logic [15:0] cal_gain_result = 16'h0000;
    logic sclk, sldn, sdata, binary_out, output_demux, decimation, ready_rate, cal_busy;
    logic [1:0] standby, input_route, clock_route, overrange_out;
    logic [15:0] applied_offset, applied_gain;
    logic [127:0] cfg_flat, exp_flat, rst_flat;
    logic [2:0] cal_mode_seen = 3'b000;
    int num_errors = 0;
    int tests_run = 0;
    int busy_cycles = 0;

    always #50 clk = ~clk;

    tw_config_port #(.CAL_CYC_AB11(24), .CAL_CYC_AB10(20), .CAL_CYC_AB01(18), .CAL_CYC_AB00(16))
    tw_config_port_inst (
        .clk(clk), .rst(rst), .sclk(sclk), .sldn(sldn), .sdata(sdata), .mode(mode),
        .overrange_in(overrange_in), .cal_offset_result(cal_offset_result),
        .cal_gain_result(cal_gain_result), .standby(standby), .binary_out(binary_out),
        .output_demux(output_demux), .input_route(input_route), .clock_route(clock_route),
        .decimation(decimation), .ready_rate(ready_rate), .cal_busy(cal_busy),
        .applied_offset(applied_offset), .applied_gain(applied_gain),
        .overrange_out(overrange_out), .cfg_flat(cfg_flat)
    );

    tw_host_model tw_host_model_inst (.clk(clk), .sclk(sclk), .sldn(sldn), .sdata(sdata));

    // Length and forced modes of the calibration phase
    always @(posedge clk) begin
        if (cal_busy === 1'b1) begin
            busy_cycles <= busy_cycles + 1;
            cal_mode_seen <= {binary_out, output_demux, decimation};
        end
    end

    function automatic logic [10:0] decode_now();
        return {standby, binary_out, output_demux, input_route, clock_route, decimation, ready_rate, cal_busy};
    endfunction

    task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d, input int nlow, input bit arm);
        tw_host_model_inst.frame(a, d, nlow, arm);
        if (nlow >= 20) exp_flat[16 * a +: 16] = d;
        repeat (6) @(posedge clk);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        rst_flat = {TW_RST_DELAY, TW_RST_SELFTEST, TW_RST_TEST, TW_RST_SETTLE,
                    TW_RST_GAIN_COMP, TW_RST_OFFSET_COMP, TW_RST_GAIN, TW_RST_MAIN};
        exp_flat = rst_flat;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        chk("reset_regs", cfg_flat, exp_flat);
        chk("reset_decode", decode_now(), {2'b00, 1'b1, 1'b0, 2'b11, 2'b10, 1'b0, 1'b0, 1'b0});
        chk("reset_comp", {applied_offset, applied_gain}, {TW_RST_OFFSET_COMP, TW_RST_GAIN_COMP});
        // All registers, frames separated by a single high cycle
        for (int i = 1; i < 8; i++) begin
            wr(3'(i), {4'(i), 12'h5A3} ^ 16'h0C30, 20, i == 1);
        end
        wr(3'h0, 16'h416B, 20, 1'b0);
        chk("all_regs", cfg_flat, exp_flat);
        chk("main_decode", decode_now(), {2'b11, 1'b0, 1'b1, 2'b10, 2'b01, 1'b1, 1'b1, 1'b0});
        chk("manual_comp", {applied_offset, applied_gain}, {exp_flat[47:32], exp_flat[63:48]});
        overrange_in <= 2'b01;
        repeat (3) @(posedge clk);
        chk("ovr_demux", overrange_out, 2'b11);
        // Frames cut short leave everything unchanged; an overlong frame writes at its twentieth low edge
        wr(3'h1, 16'hFFFF, 19, 1'b0);
        wr(3'h6, 16'h0001, 2, 1'b0);
        chk("aborted", cfg_flat, exp_flat);
        wr(3'h4, 16'h2C1E, 26, 1'b0);
        chk("overlong", cfg_flat, exp_flat);
        // Calibration start, wait bits 00
        cal_offset_result <= 16'h1357;
        cal_gain_result <= 16'h2468;
        wr(3'h0, 16'h0C00, 20, 1'b0);
        for (int k = 0; k < 200 && cal_busy !== 1'b0; k++) begin
            @(posedge clk);
        end
        chk("cal_done", cal_busy, 1'b0);
        chk("cal_length", busy_cycles, 16);
        chk("cal_modes", cal_mode_seen, 3'b101);
        wr(3'h0, 16'h4400, 20, 1'b0);
        chk("keep_comp", {applied_offset, applied_gain}, {16'h1357, 16'h2468});
        chk("keep_decode", decode_now(), 11'h000);
        overrange_in <= 2'b10;
        repeat (3) @(posedge clk);
        chk("ovr_single", overrange_out, 2'b10);
        // Calibration with wait bits 11 runs the longest phase and stores new results
        cal_offset_result <= 16'h0F1E;
        cal_gain_result <= 16'h2D3C;
        wr(3'h0, 16'h3C00, 20, 1'b0);
        for (int k = 0; k < 200 && cal_busy !== 1'b0; k++) begin
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        chk("recal_done", cal_busy, 1'b0);
        chk("recal_length", busy_cycles, 40);
        chk("recal_comp", {applied_offset, applied_gain}, {16'h0F1E, 16'h2D3C});
        // Mode pin as register reset; port refuses frames while low
        mode <= 1'b0;
        repeat (6) @(posedge clk);
        exp_flat = rst_flat;
        chk("mode_regs", cfg_flat, exp_flat);
        chk("mode_decode", decode_now(), {2'b00, 1'b1, 1'b0, 2'b11, 2'b10, 1'b0, 1'b0, 1'b0});
        tw_host_model_inst.frame(3'h5, 16'hBEEF, 20, 1'b1);
        repeat (6) @(posedge clk);
        chk("mode_refuse", cfg_flat, exp_flat);
        mode <= 1'b1;
        repeat (4) @(posedge clk);
        // No high serial edge since the port woke up, so this frame is refused
        tw_host_model_inst.frame(3'h6, 16'h1234, 20, 1'b0);
        repeat (6) @(posedge clk);
        chk("no_arm", cfg_flat, exp_flat);
        wr(3'h5, 16'h00F0, 20, 1'b1);
        chk("after_mode", cfg_flat, exp_flat);
        tally_and_finish();
    end
endmodule
